/* File: rcm_pkg.sv */
package rcm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Symbol and entry layout.
  localparam int SYM_W      = 10;
  localparam int DEC_W      = 8;
  localparam int ENT_W      = 20;
  localparam int LVL_W      = 6;
  localparam int SEQ_N      = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int E_RAW_LSB  = 0;
  localparam int E_DEC_LSB  = 10;
  localparam int E_K        = 18;
  localparam int E_DISP     = 19;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMITS = 8'h04;
  localparam logic [7:0] OFS_PRI_A  = 8'h08;
  localparam logic [7:0] OFS_PRI_B  = 8'h0C;
  localparam logic [7:0] OFS_ALT_A  = 8'h10;
  localparam logic [7:0] OFS_ALT_B  = 8'h14;
  localparam logic [7:0] OFS_MASKS  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_COUNTS = 8'h20;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int B_CC_EN     = 0;
  localparam int B_BUF_ON    = 1;
  localparam int B_ALT_ON    = 2;
  localparam int B_DEC_MATCH = 3;
  localparam int B_WIDE      = 4;
  localparam int F_DET_LSB   = 8;
  localparam int F_ADJ_LSB   = 12;
  localparam int F_HIGH_LSB  = 16;
  localparam int F_PAT_HI    = 16;
  localparam int F_ALT_MASK  = 8;
  localparam int B_ST_LOW    = 8;
  localparam int B_ST_HIGH   = 9;
  localparam int B_ST_INS    = 10;
  localparam int B_ST_DROP   = 11;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and limits.
  localparam logic [31:0]      CTRL_RST = 32'h0000_0000;
  localparam logic [LVL_W-1:0] LOW_RST  = 6'h08;
  localparam logic [LVL_W-1:0] HIGH_RST = 6'h20;
  localparam logic [LVL_W-1:0] LIM_MIN  = 6'h03;
  localparam logic [LVL_W-1:0] LIM_MAX  = 6'h30;
  localparam logic [3:0]       MASK_RST = 4'hF;
  localparam logic [SYM_W-1:0] PAT_RST  = 10'h000;
  localparam logic [SYM_W-1:0] WIDE_CMP = 10'h3FF;
  localparam logic [SYM_W-1:0] NARR_CMP = 10'h0FF;

  typedef enum logic [1:0] {
    ST_PASS = 2'b01,
    ST_INS  = 2'b10
  } rcm_state_e;

endpackage : rcm_pkg

/* File: rcm_stream_if.sv */
`timescale 1ns/1ps
interface rcm_stream_if #(parameter int W = 20);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rcm_stream_if

/* File: rcm_fifo.sv */
`timescale 1ns/1ps
module rcm_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Write and read sides.
  rcm_stream_if.snk wr,
  rcm_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic         full;
  logic         empty;

  // Extra pointer bit tells full from empty when the low bits agree.
  assign empty    = (wptr_reg == rptr_reg);
  assign full     = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (wr.valid && !full) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_reg <= '0;
    end else if (wr.valid && !full) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rptr_reg <= '0;
    end else if (rd.ready && !empty) begin
      rptr_reg <= rptr_reg + 1'b1;
    end
  end

endmodule : rcm_fifo

/* File: rcm_matcher.sv */
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module rcm_matcher (
  // Clock and reset.
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // AHB-Lite slave.
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Receive symbol stream.
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  input  wire logic [9:0]  RX_RAW,
  input  wire logic [7:0]  RX_DEC,
  input  wire logic        RX_K,
  input  wire logic        RX_DISP,
  // Elastic buffer occupancy and fill.
  input  wire logic [5:0]  BUF_LEVEL,
  output logic      [5:0]  BUF_RESET_FILL,
  // Corrected stream.
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic      [9:0]  OUT_RAW,
  output logic      [7:0]  OUT_DEC,
  output logic             OUT_K,
  output logic             OUT_DISP,
  // Shared setting for channel bonding.
  output logic             BOND_MATCH_DECODED
);

  ////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [31:0]             ctrl_reg;
  logic [rcm_pkg::LVL_W-1:0] low_latency_limit_reg;
  logic [rcm_pkg::LVL_W-1:0] high_latency_limit_reg;
  logic [rcm_pkg::SYM_W-1:0] primary_match_pattern_reg   [rcm_pkg::SEQ_N];
  logic [rcm_pkg::SYM_W-1:0] alternate_match_pattern_reg [rcm_pkg::SEQ_N];
  logic [3:0]              primary_pattern_care_mask_reg;
  logic [3:0]              alternate_pattern_care_mask_reg;
  logic [15:0]             add_count_reg;
  logic [15:0]             skip_count_reg;
  logic                    wr_pend_reg;
  logic [7:0]              wr_addr_reg;
  logic [31:0]             hrdata_reg;
  logic [31:0]             rd_mux;
  logic                    addr_phase;

  logic cc_enable;
  logic buffer_on;
  logic alternate_pattern_on;
  logic match_after_decoder;
  logic internal_width_select;
  logic [1:0] detect_length;
  logic [1:0] adjust_length;

  assign cc_enable             = ctrl_reg[rcm_pkg::B_CC_EN];
  assign buffer_on             = ctrl_reg[rcm_pkg::B_BUF_ON];
  assign alternate_pattern_on  = ctrl_reg[rcm_pkg::B_ALT_ON];
  assign match_after_decoder   = ctrl_reg[rcm_pkg::B_DEC_MATCH];
  assign internal_width_select = ctrl_reg[rcm_pkg::B_WIDE];
  // Codes hold the length minus one, so every code is a legal 1..4 length.
  assign detect_length = ctrl_reg[rcm_pkg::F_DET_LSB +: 2];
  assign adjust_length = ctrl_reg[rcm_pkg::F_ADJ_LSB +: 2];

  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT  = 1'b1;
  assign HRESP      = 1'b0;
  assign HRDATA     = hrdata_reg;

  function automatic logic [rcm_pkg::LVL_W-1:0] clamp_lim(input logic [rcm_pkg::LVL_W-1:0] v);
    if (v < rcm_pkg::LIM_MIN) begin
      return rcm_pkg::LIM_MIN;
    end else if (v > rcm_pkg::LIM_MAX) begin
      return rcm_pkg::LIM_MAX;
    end else begin
      return v;
    end
  endfunction : clamp_lim

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && HWRITE;
      wr_addr_reg <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_reg                        <= rcm_pkg::CTRL_RST;
      low_latency_limit_reg           <= rcm_pkg::LOW_RST;
      high_latency_limit_reg          <= rcm_pkg::HIGH_RST;
      primary_pattern_care_mask_reg   <= rcm_pkg::MASK_RST;
      alternate_pattern_care_mask_reg <= rcm_pkg::MASK_RST;
      for (int i = 0; i < rcm_pkg::SEQ_N; i++) begin
        primary_match_pattern_reg[i]   <= rcm_pkg::PAT_RST;
        alternate_match_pattern_reg[i] <= rcm_pkg::PAT_RST;
      end
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        rcm_pkg::OFS_CTRL: begin
          ctrl_reg <= HWDATA & 32'h0000_331F;
        end
        rcm_pkg::OFS_LIMITS: begin
          low_latency_limit_reg  <= clamp_lim(HWDATA[5:0]);
          high_latency_limit_reg <= clamp_lim(HWDATA[rcm_pkg::F_HIGH_LSB +: 6]);
        end
        rcm_pkg::OFS_PRI_A: begin
          primary_match_pattern_reg[0] <= HWDATA[9:0];
          primary_match_pattern_reg[1] <= HWDATA[rcm_pkg::F_PAT_HI +: 10];
        end
        rcm_pkg::OFS_PRI_B: begin
          primary_match_pattern_reg[2] <= HWDATA[9:0];
          primary_match_pattern_reg[3] <= HWDATA[rcm_pkg::F_PAT_HI +: 10];
        end
        rcm_pkg::OFS_ALT_A: begin
          alternate_match_pattern_reg[0] <= HWDATA[9:0];
          alternate_match_pattern_reg[1] <= HWDATA[rcm_pkg::F_PAT_HI +: 10];
        end
        rcm_pkg::OFS_ALT_B: begin
          alternate_match_pattern_reg[2] <= HWDATA[9:0];
          alternate_match_pattern_reg[3] <= HWDATA[rcm_pkg::F_PAT_HI +: 10];
        end
        rcm_pkg::OFS_MASKS: begin
          primary_pattern_care_mask_reg   <= HWDATA[3:0];
          alternate_pattern_care_mask_reg <= HWDATA[rcm_pkg::F_ALT_MASK +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Symbol window: stage 3 is the oldest symbol and the next one to leave.
  logic [rcm_pkg::ENT_W-1:0] st_reg [rcm_pkg::SEQ_N];
  logic [3:0]                st_v_reg;
  rcm_pkg::rcm_state_e       state_reg;
  logic [1:0]                ins_idx_reg;
  logic [2:0]                drop_cnt_reg;
  logic                      hold_reg;
  logic [3:0]                hit_p;
  logic [3:0]                hit_a;
  logic                      lat_low;
  logic                      lat_high;
  logic                      match_any;
  logic                      fire;
  logic                      shift;
  logic                      dropping;
  logic [1:0]                ins_sel;

  rcm_stream_if #(.W(rcm_pkg::ENT_W)) push_if ();
  rcm_stream_if #(.W(rcm_pkg::ENT_W)) pop_if ();

  assign lat_low  = BUF_LEVEL < low_latency_limit_reg;
  assign lat_high = BUF_LEVEL > high_latency_limit_reg;
  assign BUF_RESET_FILL     = low_latency_limit_reg;
  assign BOND_MATCH_DECODED = match_after_decoder;

  for (genvar i = 0; i < rcm_pkg::SEQ_N; i++) begin : g_cmp
    logic [rcm_pkg::ENT_W-1:0] e;
    logic [rcm_pkg::SYM_W-1:0] val;
    logic [rcm_pkg::SYM_W-1:0] cmp;
    logic                      used;
    // Subsequence i meets the symbol i places after the oldest one.
    assign e    = st_reg[rcm_pkg::SEQ_N-1-i];
    assign val  = match_after_decoder ?
                  {e[rcm_pkg::E_K], e[rcm_pkg::E_DISP], e[rcm_pkg::E_DEC_LSB +: 8]} :
                  e[rcm_pkg::E_RAW_LSB +: 10];
    assign cmp  = internal_width_select ? rcm_pkg::WIDE_CMP : rcm_pkg::NARR_CMP;
    assign used = (2'(i) <= detect_length);
    assign hit_p[i] = !used || !primary_pattern_care_mask_reg[i] ||
                      (((val ^ primary_match_pattern_reg[i]) & cmp) == 10'h000);
    assign hit_a[i] = !used || !alternate_pattern_care_mask_reg[i] ||
                      (((val ^ alternate_match_pattern_reg[i]) & cmp) == 10'h000);
  end

  assign match_any = &st_v_reg && (&hit_p || (alternate_pattern_on && &hit_a));
  // The hold flag stops a just-repeated sequence from matching itself again.
  assign fire      = cc_enable && buffer_on && (state_reg == rcm_pkg::ST_PASS) &&
                     (lat_low || lat_high) && match_any &&
                     (drop_cnt_reg == 3'h0) && !hold_reg;
  assign dropping  = (drop_cnt_reg != 3'h0);
  assign shift     = RX_VALID && (state_reg == rcm_pkg::ST_PASS) && !fire &&
                     (!st_v_reg[3] || dropping || push_if.ready);
  assign RX_READY  = shift;
  assign ins_sel   = 2'd3 - ins_idx_reg;

  always_comb begin
    push_if.valid = 1'b0;
    push_if.data  = st_reg[3];
    if (state_reg == rcm_pkg::ST_INS) begin
      push_if.valid = 1'b1;
      push_if.data  = st_reg[ins_sel];
    end else if (shift && st_v_reg[3] && !dropping) begin
      push_if.valid = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_v_reg <= 4'h0;
      for (int i = 0; i < rcm_pkg::SEQ_N; i++) begin
        st_reg[i] <= '0;
      end
    end else if (shift) begin
      st_reg[0] <= {RX_DISP, RX_K, RX_DEC, RX_RAW};
      st_v_reg  <= {st_v_reg[2:0], 1'b1};
      for (int i = 1; i < rcm_pkg::SEQ_N; i++) begin
        st_reg[i] <= st_reg[i-1];
      end
    end
  end

  // Repeats copy the first adjust-length bytes of the match ahead of the originals.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg   <= rcm_pkg::ST_PASS;
      ins_idx_reg <= 2'h0;
    end else begin
      case (state_reg)
        rcm_pkg::ST_PASS: begin
          ins_idx_reg <= 2'h0;
          if (fire && lat_low) begin
            state_reg <= rcm_pkg::ST_INS;
          end
        end
        rcm_pkg::ST_INS: begin
          if (push_if.ready) begin
            ins_idx_reg <= ins_idx_reg + 2'h1;
            if (ins_idx_reg == adjust_length) begin
              state_reg <= rcm_pkg::ST_PASS;
            end
          end
        end
        default: begin
          state_reg   <= rcm_pkg::ST_PASS;
          ins_idx_reg <= 2'h0;
        end
      endcase
    end
  end

  // Deletion discards the next adjust-length bytes, starting with the match's first.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      drop_cnt_reg <= 3'h0;
    end else if (fire && !lat_low && lat_high) begin
      drop_cnt_reg <= {1'b0, adjust_length} + 3'h1;
    end else if (shift && dropping) begin
      drop_cnt_reg <= drop_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hold_reg <= 1'b0;
    end else if (state_reg == rcm_pkg::ST_INS) begin
      hold_reg <= 1'b1;
    end else if (shift) begin
      hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      add_count_reg  <= 16'h0000;
      skip_count_reg <= 16'h0000;
    end else if (fire && lat_low) begin
      add_count_reg  <= add_count_reg + 16'h0001;
    end else if (fire) begin
      skip_count_reg <= skip_count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side. Data is sampled in the address phase, so a read right after
  // a write to the same register returns the old value.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (HADDR[7:0])
      rcm_pkg::OFS_CTRL:   rd_mux = ctrl_reg;
      rcm_pkg::OFS_LIMITS: rd_mux = {10'h000, high_latency_limit_reg, 10'h000,
                                     low_latency_limit_reg};
      rcm_pkg::OFS_PRI_A:  rd_mux = {6'h00, primary_match_pattern_reg[1], 6'h00,
                                     primary_match_pattern_reg[0]};
      rcm_pkg::OFS_PRI_B:  rd_mux = {6'h00, primary_match_pattern_reg[3], 6'h00,
                                     primary_match_pattern_reg[2]};
      rcm_pkg::OFS_ALT_A:  rd_mux = {6'h00, alternate_match_pattern_reg[1], 6'h00,
                                     alternate_match_pattern_reg[0]};
      rcm_pkg::OFS_ALT_B:  rd_mux = {6'h00, alternate_match_pattern_reg[3], 6'h00,
                                     alternate_match_pattern_reg[2]};
      rcm_pkg::OFS_MASKS:  rd_mux = {20'h00000, alternate_pattern_care_mask_reg, 4'h0,
                                     primary_pattern_care_mask_reg};
      rcm_pkg::OFS_STATUS: rd_mux = {20'h00000, dropping, state_reg == rcm_pkg::ST_INS,
                                     lat_high, lat_low, 2'h0, BUF_LEVEL};
      rcm_pkg::OFS_COUNTS: rd_mux = {skip_count_reg, add_count_reg};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE) begin
      hrdata_reg <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer; a stalled consumer backs up into RX_READY.
  rcm_fifo #(
    .W     (rcm_pkg::ENT_W),
    .DEPTH (rcm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk (CLK_SYS),
    .rst (RST),
    .wr  (push_if.snk),
    .rd  (pop_if.src)
  );

  assign pop_if.ready = OUT_READY;
  assign OUT_VALID    = pop_if.valid;
  assign OUT_RAW      = pop_if.data[rcm_pkg::E_RAW_LSB +: 10];
  assign OUT_DEC      = pop_if.data[rcm_pkg::E_DEC_LSB +: 8];
  assign OUT_K        = pop_if.data[rcm_pkg::E_K];
  assign OUT_DISP     = pop_if.data[rcm_pkg::E_DISP];

endmodule : rcm_matcher

/* File: rcm_matcher_asserts.sv */
`timescale 1ns/1ps
module rcm_matcher_asserts (
  // Clock and reset.
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Register bus.
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Streams and settings.
  input wire logic        RX_VALID,
  input wire logic        RX_READY,
  input wire logic [5:0]  BUF_RESET_FILL,
  input wire logic        OUT_VALID,
  input wire logic        OUT_READY,
  input wire logic [9:0]  OUT_RAW,
  input wire logic        BOND_MATCH_DECODED
);
  logic       addr_ok;
  logic       wr_ctrl_reg;
  logic       wr_lim_reg;
  logic       rd_ph_reg;
  logic       cc_on_reg;
  logic [5:0] lim_exp_reg;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  //////////////////////////////////////////////////////////////////////////////
  // Control and limit writes are shadowed here, since the checker cannot see the registers.
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  function automatic logic [5:0] clamp(input logic [5:0] v);
    if (v < rcm_pkg::LIM_MIN) return rcm_pkg::LIM_MIN;
    if (v > rcm_pkg::LIM_MAX) return rcm_pkg::LIM_MAX;
    return v;
  endfunction : clamp

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_ctrl_reg <= 1'b0;
      wr_lim_reg  <= 1'b0;
      rd_ph_reg   <= 1'b0;
      cc_on_reg   <= 1'b0;
      lim_exp_reg <= rcm_pkg::LOW_RST;
    end else begin
      wr_ctrl_reg <= addr_ok && HWRITE && HADDR[7:0] == rcm_pkg::OFS_CTRL;
      wr_lim_reg  <= addr_ok && HWRITE && HADDR[7:0] == rcm_pkg::OFS_LIMITS;
      rd_ph_reg   <= addr_ok && !HWRITE;
      if (wr_ctrl_reg) cc_on_reg <= HWDATA[rcm_pkg::B_CC_EN] && HWDATA[rcm_pkg::B_BUF_ON];
      if (wr_lim_reg) lim_exp_reg <= clamp(HWDATA[5:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  fill_reset_a: assert property ($fell(RST) |-> BUF_RESET_FILL == rcm_pkg::LOW_RST)
    else $error("Buffer fill differs from the low limit after reset.");
  fill_range_a: assert property (BUF_RESET_FILL inside {[6'h03:6'h30]})
    else $error("Buffer fill out of range.");
  fill_write_a: assert property ($changed(BUF_RESET_FILL) || $past(wr_lim_reg) |->
    $past(wr_lim_reg) && BUF_RESET_FILL == lim_exp_reg)
    else $error("Buffer fill does not follow the clamped low limit.");
  bond_ctrl_a: assert property ($changed(BOND_MATCH_DECODED) |-> $past(wr_ctrl_reg) &&
    BOND_MATCH_DECODED == $past(HWDATA[rcm_pkg::B_DEC_MATCH]))
    else $error("Bonding match select moved without a control write.");
  off_stall_a: assert property (RX_VALID && !RX_READY && !cc_on_reg |-> OUT_VALID)
    else $error("Input stalled while correction is off and output is empty.");
  out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_RAW))
    else $error("Output symbol changed while stalled.");
  hrdata_hold_a: assert property ($changed(HRDATA) |-> rd_ph_reg)
    else $error("Read data changed without a read.");
  zero_wait_a: assert property (addr_ok |-> HREADYOUT ##1 HREADYOUT && !HRESP)
    else $error("Bus transfer not answered at once with OKAY.");
endmodule : rcm_matcher_asserts

/* File: rcm_tx_model.sv */
`timescale 1ns/1ps
module rcm_tx_model (
  // Clock.
  input wire logic clk,
  // Symbol lane into the matcher.
  input wire logic rx_ready,
  output logic       rx_valid,
  output logic [9:0] rx_raw,
  output logic [7:0] rx_dec,
  output logic       rx_k,
  output logic       rx_disp
);
  logic [19:0] ent_reg;
  int          acc;

  initial begin
    rx_valid = 1'b0;
    ent_reg  = 20'h0_0000;
    acc      = 0;
  end

  assign {rx_disp, rx_k, rx_dec, rx_raw} = ent_reg;

  // Idle lanes carry the inverse of the last symbol so a stale value never looks valid.
  task automatic play(input logic [19:0] s[$], input int gap);
    acc = 0;
    foreach (s[i]) begin
      rx_valid <= 1'b1;
      ent_reg  <= s[i];
      do @(posedge clk); while (!rx_ready);
      acc++;
      if (gap > 0) begin
        rx_valid <= 1'b0;
        ent_reg  <= ~s[i];
        repeat (gap) @(posedge clk);
      end
    end
    rx_valid <= 1'b0;
    if (gap == 0) ent_reg <= ~ent_reg;
  endtask : play
endmodule : rcm_tx_model

/* File: test_rcm_matcher.sv */
`timescale 1ns/1ps
module test_rcm_matcher;
  logic        CLK_SYS, RST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic        RX_VALID, RX_READY, RX_K, RX_DISP, OUT_VALID, OUT_READY, OUT_K, OUT_DISP;
  logic [9:0]  RX_RAW, OUT_RAW;
  logic [7:0]  RX_DEC, OUT_DEC;
  logic [5:0]  BUF_LEVEL, BUF_RESET_FILL;
  logic        BOND_MATCH_DECODED;
  int          fails, n_checks;
  logic [19:0] stim[$], expq[$], got[$];

  rcm_matcher i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .RX_RAW(RX_RAW), .RX_DEC(RX_DEC), .RX_K(RX_K), .RX_DISP(RX_DISP),
    .BUF_LEVEL(BUF_LEVEL), .BUF_RESET_FILL(BUF_RESET_FILL), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_RAW(OUT_RAW), .OUT_DEC(OUT_DEC), .OUT_K(OUT_K),
    .OUT_DISP(OUT_DISP), .BOND_MATCH_DECODED(BOND_MATCH_DECODED));
  rcm_tx_model i_tx (.clk(CLK_SYS), .rx_ready(RX_READY), .rx_valid(RX_VALID), .rx_raw(RX_RAW),
    .rx_dec(RX_DEC), .rx_k(RX_K), .rx_disp(RX_DISP));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS) begin
    if (!RST && OUT_VALID && OUT_READY) got.push_back({OUT_DISP, OUT_K, OUT_DEC, OUT_RAW});
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] mk(input logic [9:0] w, input logic [7:0] b,
                                     input logic k, input logic p);
    return {p, k, b, w};
  endfunction : mk

  function automatic logic [19:0] r(input logic [9:0] w);
    return mk(w, 8'h00, 1'b0, 1'b0);
  endfunction : r

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic conclude;
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    HSEL   <= 1'b1;
    HADDR  <= {24'h00_0000, a};
    HWRITE <= w;
    HTRANS <= 2'b10;
    do @(posedge CLK_SYS); while (!HREADYOUT);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (!HREADYOUT);
    d = HRDATA;
  endtask : ahb

  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    ahb(1'b1, a, v, d);
  endtask : wrt

  task automatic rc(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    check(d, want);
  endtask : rc

  task automatic prep(input logic [31:0] ctl, input logic [5:0] lvl);
    RST <= 1'b1;
    repeat (16) @(posedge CLK_SYS);
    RST       <= 1'b0;
    BUF_LEVEL <= lvl;
    @(posedge CLK_SYS);
    wrt(rcm_pkg::OFS_CTRL, ctl);
  endtask : prep

  // The last four symbols stay in the match window, so expectations leave them out.
  task automatic run(input int gap);
    got.delete();
    i_tx.play(stim, gap);
    repeat (20) @(posedge CLK_SYS);
    check(got.size(), expq.size());
    foreach (expq[i]) check(got[i], expq[i]);
  endtask : run

  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_regs;
    prep(32'h0, 6'h10);
    rc(rcm_pkg::OFS_LIMITS, 32'h0020_0008);
    rc(rcm_pkg::OFS_MASKS, 32'h0000_0F0F);
    rc(8'h24, 32'h0);
    wrt(rcm_pkg::OFS_LIMITS, 32'h003F_0001);
    wrt(rcm_pkg::OFS_PRI_A, 32'hFFFF_FFFF);
    wrt(rcm_pkg::OFS_COUNTS, 32'hFFFF_FFFF);
    rc(rcm_pkg::OFS_LIMITS, 32'h0030_0003);
    check(BUF_RESET_FILL, 6'h03);
    rc(rcm_pkg::OFS_STATUS, 32'h0000_0010);
    rc(rcm_pkg::OFS_PRI_A, 32'h03FF_03FF);
    rc(rcm_pkg::OFS_ALT_A, 32'h0);
    rc(rcm_pkg::OFS_COUNTS, 32'h0);
    wrt(rcm_pkg::OFS_CTRL, 32'hFFFF_FFFF);
    rc(rcm_pkg::OFS_CTRL, 32'h0000_331F);
    check(BOND_MATCH_DECODED, 1'b1);
  endtask : sc_regs

  task automatic sc_off;
    logic [31:0] ctl[2] = '{32'h0000_0011, 32'h0000_0012};
    for (int i = 0; i < 2; i++) begin
      stim = '{r(10'h17C), r(10'h101), r(10'h102), r(10'h103), r(10'h104), r(10'h105)};
      prep(ctl[i], 6'h04);
      wrt(rcm_pkg::OFS_PRI_A, 32'h0000_017C);
      expq = stim[0:1];
      run(2);
    end
  endtask : sc_off

  // A level equal to the low limit is not below it, so only the second pass inserts.
  task automatic sc_insert;
    for (int i = 0; i < 2; i++) begin
      stim = '{r(10'h101), r(10'h102), r(10'h17C), r(10'h111), r(10'h112), r(10'h113),
               r(10'h114), r(10'h115)};
      prep(32'h0000_1013, i ? 6'h07 : 6'h08);
      wrt(rcm_pkg::OFS_PRI_A, 32'h0000_017C);
      if (i == 0) expq = stim[0:3];
      else expq = '{stim[0], stim[1], stim[2], stim[3], stim[2], stim[3]};
      run(0);
      rc(rcm_pkg::OFS_COUNTS, i);
    end
  endtask : sc_insert

  task automatic sc_delete;
    for (int i = 0; i < 2; i++) begin
      stim = '{r(10'h101), r(10'h283), r(10'h111), r(10'h112), r(10'h113), r(10'h114),
               r(10'h115), r(10'h116), r(10'h117), r(10'h118)};
      prep(i ? 32'h0000_2017 : 32'h0000_2013, 6'h21);
      wrt(rcm_pkg::OFS_ALT_A, 32'h0000_0283);
      if (i == 0) expq = stim[0:5];
      else expq = '{stim[0], stim[4], stim[5]};
      run(1);
      rc(rcm_pkg::OFS_COUNTS, i ? 32'h0001_0000 : 32'h0);
    end
  endtask : sc_delete

  // Disparity is ignored only when the narrow width drops the upper two bits.
  task automatic sc_decoded;
    logic [31:0] ctl[3] = '{32'h0000_011B, 32'h0000_011B, 32'h0000_010B};
    logic        dsp[3] = '{1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 3; i++) begin
      stim = '{mk(10'h0F1, 8'h11, 1'b0, 1'b0), mk(10'h0F2, 8'hBC, 1'b1, dsp[i]),
               mk(10'h0F3, 8'h13, 1'b0, 1'b0), mk(10'h0F4, 8'h14, 1'b0, 1'b0),
               mk(10'h0F5, 8'h15, 1'b0, 1'b0), mk(10'h0F6, 8'h16, 1'b0, 1'b0)};
      prep(ctl[i], 6'h07);
      wrt(rcm_pkg::OFS_PRI_A, 32'h02BC_0000);
      wrt(rcm_pkg::OFS_MASKS, 32'h0000_0F02);
      if (i == 1) expq = stim[0:1];
      else expq = '{stim[0], stim[0], stim[1]};
      run(0);
      check(BOND_MATCH_DECODED, 1'b1);
    end
  endtask : sc_decoded

  task automatic sc_fifo;
    prep(32'h0, 6'h10);
    stim.delete();
    for (int i = 0; i < 14; i++) stim.push_back(r(10'h200 + 10'(i)));
    got.delete();
    OUT_READY <= 1'b0;
    fork
      i_tx.play(stim, 0);
    join_none
    repeat (40) @(posedge CLK_SYS);
    check(i_tx.acc, 12);
    check(OUT_VALID, 1'b1);
    OUT_READY <= 1'b1;
    repeat (40) @(posedge CLK_SYS);
    check(got.size(), 10);
    foreach (got[i]) check(got[i], stim[i]);
  endtask : sc_fifo

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    RST       = 1'b1;
    HSEL      = 1'b0;
    HADDR     = 32'h0;
    HTRANS    = 2'b00;
    HWRITE    = 1'b0;
    HSIZE     = 3'b010;
    HWDATA    = 32'h0;
    BUF_LEVEL = 6'h00;
    OUT_READY = 1'b1;
    fails     = 0;
    n_checks  = 0;
    @(posedge CLK_SYS);
    sc_regs();
    sc_off();
    sc_insert();
    sc_delete();
    sc_decoded();
    sc_fifo();
    conclude();
  end

  // The whole run needs about six hundred and fifty cycles.
  initial begin
    repeat (6000) @(posedge CLK_SYS);
    fails++;
    conclude();
  end
endmodule : test_rcm_matcher

bind rcm_matcher rcm_matcher_asserts i_chk (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
  .RX_READY(RX_READY), .BUF_RESET_FILL(BUF_RESET_FILL), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .OUT_RAW(OUT_RAW), .BOND_MATCH_DECODED(BOND_MATCH_DECODED));
